// file: rtl/cnmix_pkg.sv
//
// Contract
// - 32-bit accumulator, 10-bit offset adder, sine table
// - Increment is center plus offset, modulo 2^32
// - Offset-zero bit forces offset contribution zero
// - Accumulator advances only while enable low
// - Frequency word is two's complement
// - Phase offset adds to accumulator MSBs
// - Top 18 phase bits address 18-bit table
// - Sample times cosine gives I, sine Q
// - Products round symmetrically to 15 bits
// - Holding registers; word five/six writes transfer
// - Sync input transfers both when enabled
// - Clear bit zeroes feedback on transfer
// - Serial width 8/16/24/32 from two-bit field
// - Carrier serial data shifted in every clock edge
// - Resampler port runs on processing clock
// - One-cycle strobe precedes first data bit
// - Word left-aligned into 32-bit holding register
// - Countdown from strobe; next word right after
package cnmix_pkg;
   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [7:0] CNMIX_OFF_CFG0     = 8'h00;  // Mode bits, carrier width
   localparam logic [7:0] CNMIX_OFF_CFG1     = 8'h04;  // Sync update enable
   localparam logic [7:0] CNMIX_OFF_CFREQ    = 8'h0C;  // Center frequency holding
   localparam logic [7:0] CNMIX_OFF_PHOFF    = 8'h10;  // Phase offset holding
   localparam logic [7:0] CNMIX_OFF_XFRQ     = 8'h14;  // Frequency transfer strobe
   localparam logic [7:0] CNMIX_OFF_XPHS     = 8'h18;  // Phase transfer strobe
   localparam logic [7:0] CNMIX_OFF_CFG11    = 8'h2C;  // Resampler width
   localparam logic [7:0] CNMIX_OFF_ACTFREQ  = 8'h40;  // Active frequency, read only
   localparam logic [7:0] CNMIX_OFF_ACTPHS   = 8'h44;  // Active phase, read only
   localparam logic [7:0] CNMIX_OFF_COFHOLD  = 8'h48;  // Carrier serial word, read only
   localparam logic [7:0] CNMIX_OFF_SOFHOLD  = 8'h4C;  // Resampler serial word, read only
   localparam logic [7:0] CNMIX_OFF_ACC      = 8'h50;  // Phase accumulator, read only
   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int CNMIX_B_ACCCLR   = 0;   // Cfg0 accumulator clear on transfer
   localparam int CNMIX_B_OFFZERO  = 1;   // Cfg0 offset frequency zero
   localparam int CNMIX_B_CWIDTH   = 4;   // Cfg0 carrier width field LSB
   localparam int CNMIX_B_SYNCUPD  = 20;  // Cfg1 sync update enable
   localparam int CNMIX_B_RWIDTH   = 3;   // Cfg11 resampler width field LSB
   // ----------------------------------------
   // Widths, counts and reset values
   // ----------------------------------------
   localparam int          CNMIX_PO_W     = 10;           // Phase offset width
   localparam int          CNMIX_ADDR_W   = 18;           // Table address width
   localparam logic [31:0] CNMIX_RST_WORD = 32'h0000_0000;
   localparam logic [16:0] CNMIX_AMP_MAX  = 17'h1_FFFF;   // Table peak magnitude
   localparam logic [17:0] CNMIX_HALF     = 18'h2_0000;   // Half cycle of phase
   localparam logic [31:0] CNMIX_RND_POS  = 32'h0000_8000;
   localparam logic [31:0] CNMIX_RND_NEG  = 32'h0000_7FFF;
endpackage : cnmix_pkg

// file: rtl/cnmix_top.sv
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
module cnmix_top (
   input  wire logic               clk,                          // Input clock
   input  wire logic               rst_n,                        // Async reset
   input  wire logic               psel,                         // APB select
   input  wire logic               penable,                      // APB enable
   input  wire logic               pwrite,                       // APB direction
   input  wire logic [7:0]         paddr,                        // APB byte address
   input  wire logic [31:0]        pwdata,                       // APB write data
   output logic      [31:0]        prdata,                       // APB read data
   output logic                    pready,                       // APB ready
   output logic                    pslverr,                      // APB error
   input  wire logic               input_sample_enable_n,        // Sample enable, low
   input  wire logic signed [13:0] mix_sample_in,                // Input sample
   input  wire logic               front_end_sync_in,            // External sync
   input  wire logic               carrier_offset_serial_data,   // Carrier serial bit
   input  wire logic               carrier_offset_word_strobe,   // Carrier word start
   input  wire logic               processing_clock_en,          // Processing rate pulse
   input  wire logic               resampler_offset_serial_data, // Resampler serial bit
   input  wire logic               resampler_offset_word_strobe, // Resampler word start
   output logic signed [14:0]      mix_i_out,                    // I product
   output logic signed [14:0]      mix_q_out,                    // Q product
   output logic                    mix_valid,                    // Product valid pulse
   output logic      [31:0]        resampler_offset_word         // Resampler held word
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [31:0]       acc;        // Phase accumulator
      logic [31:0]       freq_hold;  // Center frequency holding
      logic [31:0]       freq_act;   // Center frequency active
      logic [9:0]        po_hold;    // Phase offset holding
      logic [9:0]        po_act;     // Phase offset active
      logic [5:0]        cfg0;       // Mode bits and carrier width
      logic              sync_upd;   // Sync update enable
      logic [1:0]        rs_width;   // Resampler width code
      logic              sync_d;     // Sync delayed for edge
      logic [1:0][31:0]  sh;         // Serial shift registers
      logic [1:0][5:0]   cnt;        // Bits still to come
      logic [1:0]        busy;       // Word in progress
      logic [1:0][31:0]  hold;       // Serial holding registers
      logic [14:0]       mix_i;      // I output
      logic [14:0]       mix_q;      // Q output
      logic              mix_v;      // Output valid
      logic [31:0]       rdata;      // Read data
      logic              ready;      // Ready
      logic              err;        // Error
   } cnmix_state_s;

   cnmix_state_s st_reg;   // Registered state
   cnmix_state_s st_next;  // Next state

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   // Parabolic half-wave sine, phase in full cycles of 2^18
   function automatic logic signed [17:0] cnmix_sine(input logic [17:0] ph);
      logic [16:0] h;
      logic [17:0] c;
      logic [34:0] p;
      logic [16:0] a;
      h = ph[16:0];
      c = cnmix_pkg::CNMIX_HALF - {1'b0, h};
      p = h * c;
      // Clamp the single peak point that reaches 2^17
      if (p[34:15] > {3'b000, cnmix_pkg::CNMIX_AMP_MAX}) begin
         a = cnmix_pkg::CNMIX_AMP_MAX;
      end else begin
         a = p[31:15];
      end
      cnmix_sine = ph[17] ? -$signed({1'b0, a}) : $signed({1'b0, a});
   endfunction : cnmix_sine

   // Symmetric rounding to 15 bits, halves away from zero
   function automatic logic [14:0] cnmix_round(input logic signed [31:0] p);
      logic [31:0] r;
      r = p[31] ? 32'(p + cnmix_pkg::CNMIX_RND_NEG) : 32'(p + cnmix_pkg::CNMIX_RND_POS);
      cnmix_round = r[30:16];
   endfunction : cnmix_round

   // Serial word length in bits from width code
   function automatic logic [5:0] cnmix_bits(input logic [1:0] w);
      // Widen before adding so code 11 gives 32, not a wrapped 0
      cnmix_bits = {1'b0, w, 3'b000} + 6'd8;
   endfunction : cnmix_bits

   // ----------------------------------------
   // Datapath decode
   // ----------------------------------------
   logic        apb_wr;     // Write access phase
   logic        xfer_frq;   // Frequency transfer event
   logic        xfer_phs;   // Phase transfer event
   logic        sync_rise;  // Sync rising edge
   logic [31:0] inc;        // Accumulator increment
   logic [17:0] addr;       // Table address

   always_comb begin
      apb_wr    = psel && penable && pwrite && st_reg.ready;
      sync_rise = front_end_sync_in && !st_reg.sync_d;
      // Processor write transfers, or sync transfers both
      xfer_frq  = (apb_wr && paddr == cnmix_pkg::CNMIX_OFF_XFRQ) || (sync_rise && st_reg.sync_upd);
      xfer_phs  = (apb_wr && paddr == cnmix_pkg::CNMIX_OFF_XPHS) || (sync_rise && st_reg.sync_upd);
      // Two's complement sum wraps naturally at 32 bits
      inc = st_reg.freq_act + (st_reg.cfg0[cnmix_pkg::CNMIX_B_OFFZERO] ? 32'h0000_0000 : st_reg.hold[0]);
      // Offset adds to top ten bits, wrapping at one cycle
      addr = {st_reg.acc[31:22] + st_reg.po_act, st_reg.acc[21:14]};
   end

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb begin
      logic        clr;
      logic [31:0] fb;
      logic        step;
      logic        sdat;
      logic        sstb;
      logic [1:0]  wcode;
      logic [31:0] shn;
      logic signed [17:0] cosv;
      logic signed [17:0] sinv;
      logic signed [31:0] pi;
      logic signed [31:0] pq;
      clr   = 1'b0;
      fb    = 32'h0000_0000;
      step  = 1'b0;
      sdat  = 1'b0;
      sstb  = 1'b0;
      wcode = 2'b00;
      shn   = 32'h0000_0000;
      cosv  = 18'sh0_0000;
      sinv  = 18'sh0_0000;
      pi    = 32'sh0000_0000;
      pq    = 32'sh0000_0000;
      st_next = st_reg;
      st_next.sync_d = front_end_sync_in;

      // Oscillator: clear feedback on transfer when enabled
      clr = (xfer_frq || xfer_phs) && st_reg.cfg0[cnmix_pkg::CNMIX_B_ACCCLR];
      fb  = clr ? 32'h0000_0000 : st_reg.acc;
      // Advance only on enabled samples
      st_next.acc = input_sample_enable_n ? fb : 32'(fb + inc);

      // Holding to active transfers
      if (xfer_frq) begin
         st_next.freq_act = st_reg.freq_hold;
      end
      if (xfer_phs) begin
         st_next.po_act = st_reg.po_hold;
      end

      // Mixer on enabled samples
      cosv = cnmix_sine(18'(addr + (cnmix_pkg::CNMIX_HALF >> 1)));
      sinv = cnmix_sine(addr);
      pi   = mix_sample_in * cosv;
      pq   = mix_sample_in * sinv;
      st_next.mix_v = !input_sample_enable_n;
      if (!input_sample_enable_n) begin
         st_next.mix_i = cnmix_round(pi);
         st_next.mix_q = cnmix_round(pq);
      end

      // Serial ports: 0 carrier every clock, 1 resampler on rate pulse
      for (int k = 0; k < 2; k++) begin
         step  = (k == 0) ? 1'b1 : processing_clock_en;
         sdat  = (k == 0) ? carrier_offset_serial_data : resampler_offset_serial_data;
         sstb  = (k == 0) ? carrier_offset_word_strobe : resampler_offset_word_strobe;
         wcode = (k == 0) ? st_reg.cfg0[cnmix_pkg::CNMIX_B_CWIDTH +: 2] : st_reg.rs_width;
         shn   = {st_reg.sh[k][30:0], sdat};
         if (step) begin
            if (sstb) begin
               // Strobe starts countdown; data follows next step
               st_next.cnt[k]  = cnmix_bits(wcode);
               st_next.busy[k] = 1'b1;
               st_next.sh[k]   = 32'h0000_0000;
            end else if (st_reg.busy[k]) begin
               // MSB first, one bit per step
               st_next.sh[k]  = shn;
               st_next.cnt[k] = st_reg.cnt[k] - 6'd1;
               if (st_reg.cnt[k] == 6'd1) begin
                  // Left-align; low bits cleared
                  st_next.hold[k] = shn << (6'd32 - cnmix_bits(wcode));
                  st_next.busy[k] = 1'b0;
               end
            end
         end
      end

      // APB: answer prepared in setup, ready every access
      st_next.ready = 1'b1;
      if (psel && !penable) begin
         st_next.err   = 1'b0;
         st_next.rdata = 32'h0000_0000;
         if (paddr == cnmix_pkg::CNMIX_OFF_CFG0) begin
            st_next.rdata = {26'h000_0000, st_reg.cfg0};
         end else if (paddr == cnmix_pkg::CNMIX_OFF_CFG1) begin
            st_next.rdata = 32'(st_reg.sync_upd) << cnmix_pkg::CNMIX_B_SYNCUPD;
         end else if (paddr == cnmix_pkg::CNMIX_OFF_CFREQ) begin
            st_next.rdata = st_reg.freq_hold;
         end else if (paddr == cnmix_pkg::CNMIX_OFF_PHOFF) begin
            st_next.rdata = {22'h00_0000, st_reg.po_hold};
         end else if (paddr == cnmix_pkg::CNMIX_OFF_XFRQ || paddr == cnmix_pkg::CNMIX_OFF_XPHS) begin
            st_next.rdata = 32'h0000_0000;
         end else if (paddr == cnmix_pkg::CNMIX_OFF_CFG11) begin
            st_next.rdata = 32'(st_reg.rs_width) << cnmix_pkg::CNMIX_B_RWIDTH;
         end else if (paddr == cnmix_pkg::CNMIX_OFF_ACTFREQ) begin
            st_next.rdata = st_reg.freq_act;
         end else if (paddr == cnmix_pkg::CNMIX_OFF_ACTPHS) begin
            st_next.rdata = {22'h00_0000, st_reg.po_act};
         end else if (paddr == cnmix_pkg::CNMIX_OFF_COFHOLD) begin
            st_next.rdata = st_reg.hold[0];
         end else if (paddr == cnmix_pkg::CNMIX_OFF_SOFHOLD) begin
            st_next.rdata = st_reg.hold[1];
         end else if (paddr == cnmix_pkg::CNMIX_OFF_ACC) begin
            st_next.rdata = st_reg.acc;
         end else begin
            // Unmapped: zero data, error
            st_next.err = 1'b1;
         end
      end

      // Register writes at the access edge
      if (apb_wr) begin
         if (paddr == cnmix_pkg::CNMIX_OFF_CFG0) begin
            st_next.cfg0 = pwdata[5:0];
         end else if (paddr == cnmix_pkg::CNMIX_OFF_CFG1) begin
            st_next.sync_upd = pwdata[cnmix_pkg::CNMIX_B_SYNCUPD];
         end else if (paddr == cnmix_pkg::CNMIX_OFF_CFREQ) begin
            st_next.freq_hold = pwdata;
         end else if (paddr == cnmix_pkg::CNMIX_OFF_PHOFF) begin
            st_next.po_hold = pwdata[cnmix_pkg::CNMIX_PO_W-1:0];
         end else if (paddr == cnmix_pkg::CNMIX_OFF_CFG11) begin
            st_next.rs_width = pwdata[cnmix_pkg::CNMIX_B_RWIDTH +: 2];
         end
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   always_comb begin
      prdata                = st_reg.rdata;
      pready                = st_reg.ready;
      pslverr               = st_reg.err;
      mix_i_out             = st_reg.mix_i;
      mix_q_out             = st_reg.mix_q;
      mix_valid             = st_reg.mix_v;
      resampler_offset_word = st_reg.hold[1];
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_cof_start8;
      carrier_offset_word_strobe && st_reg.cfg0[5:4] == 2'b00 && st_reg.ready;
   endsequence
   sequence s_cof_bits8;
      !carrier_offset_word_strobe [*8];
   endsequence

   property p_acc_hold;
      input_sample_enable_n && !xfer_frq && !xfer_phs |=> $stable(st_reg.acc);
   endproperty
   a_acc_hold: assert property (p_acc_hold) else $error("Accumulator moved while disabled");

   property p_acc_step;
      !input_sample_enable_n && !xfer_frq && !xfer_phs |=> st_reg.acc == 32'($past(st_reg.acc) + $past(inc));
   endproperty
   a_acc_step: assert property (p_acc_step) else $error("Accumulator step wrong");

   property p_offzero;
      st_reg.cfg0[1] |-> inc == st_reg.freq_act;
   endproperty
   a_offzero: assert property (p_offzero) else $error("Offset not zeroed");

   property p_cw5;
      apb_wr && paddr == cnmix_pkg::CNMIX_OFF_XFRQ |=> st_reg.freq_act == $past(st_reg.freq_hold);
   endproperty
   a_cw5: assert property (p_cw5) else $error("Frequency transfer missed");

   property p_sync;
      front_end_sync_in && !st_reg.sync_d && st_reg.sync_upd
         |=> st_reg.freq_act == $past(st_reg.freq_hold) && st_reg.po_act == $past(st_reg.po_hold);
   endproperty
   a_sync: assert property (p_sync) else $error("Sync transfer missed");

   property p_clear;
      (xfer_frq || xfer_phs) && st_reg.cfg0[0] && input_sample_enable_n |=> st_reg.acc == 32'h0000_0000;
   endproperty
   a_clear: assert property (p_clear) else $error("Feedback not cleared");

   property p_serial8;
      s_cof_start8 ##1 s_cof_bits8 |=> st_reg.hold[0][23:0] == 24'h00_0000 && !st_reg.busy[0];
   endproperty
   a_serial8: assert property (p_serial8) else $error("Eight-bit word not loaded");

   property p_mix_valid;
      !input_sample_enable_n |=> mix_valid ##1 (mix_valid == !$past(input_sample_enable_n));
   endproperty
   a_mix_valid: assert property (p_mix_valid) else $error("Mixer valid wrong");
endmodule : cnmix_top

// file: dv/cnmix_serial_src.sv
`timescale 1ns/10ps
// Serial offset source standing in for the tracking loop
module cnmix_serial_src (
   input  wire logic        clk,    // Port clock
   input  wire logic        rst_n,  // Async reset
   input  wire logic        step,   // Sampling pulse
   input  wire logic        go,     // Start a word
   input  wire logic [1:0]  wcode,  // Width code
   input  wire logic [31:0] word,   // Left-aligned word
   output logic             sdata,  // Serial bit
   output logic             strobe, // Word start
   output logic             busy    // Word in flight
);
   logic [5:0]  left; // Bits still to send
   logic [31:0] sh;   // Outgoing shift
   logic        pend; // Strobe due
   // Strobe one step, then bits, then a flipped idle bit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {left, sh, pend, sdata, strobe, busy} <= '0;
      end else if (go) begin
         busy <= 1'b1;
         pend <= 1'b1;
         sh   <= word;
         left <= {1'b0, wcode, 3'b000} + 6'd8;
      end else if (step) begin
         strobe <= pend;
         pend   <= 1'b0;
         if (!pend && left != 6'd0) begin
            sdata <= sh[31];
            sh    <= sh << 1;
            left  <= left - 6'd1;
         end else if (!pend && busy) begin
            sdata <= ~sdata; // Released line, no stale bit
            busy  <= 1'b0;
         end
      end
   end
endmodule : cnmix_serial_src

// file: dv/carrier_nco_mixer_bench.sv
`timescale 1ns/10ps
module carrier_nco_mixer_bench;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic               clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0]         paddr;
   logic [31:0]        pwdata, prdata, rd, cword, rword;
   logic               en_n, sync, pce, csd, cst, cgo, cbusy, rsd, rst, rgo, rbusy, mv;
   logic [1:0]         wc;
   logic signed [13:0] smp;
   logic signed [14:0] mi, mq;
   int                 n_errors, comparisons;
   // ----------------------------------------
   // Clock, rate pulse, instances
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Processing rate pulse every other cycle
   always @(posedge clk) pce <= ~pce;
   cnmix_top cnmix_top_i (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .input_sample_enable_n(en_n), .mix_sample_in(smp), .front_end_sync_in(sync),
      .carrier_offset_serial_data(csd), .carrier_offset_word_strobe(cst), .processing_clock_en(pce),
      .resampler_offset_serial_data(rsd), .resampler_offset_word_strobe(rst), .mix_i_out(mi),
      .mix_q_out(mq), .mix_valid(mv), .resampler_offset_word(rword));
   cnmix_serial_src cnmix_serial_src_c_i (.clk(clk), .rst_n(rst_n), .step(1'b1), .go(cgo), .wcode(wc),
      .word(cword), .sdata(csd), .strobe(cst), .busy(cbusy));
   cnmix_serial_src cnmix_serial_src_r_i (.clk(clk), .rst_n(rst_n), .step(pce), .go(rgo), .wcode(wc),
      .word(cword), .sdata(rsd), .strobe(rst), .busy(rbusy));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic complete_run;
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : complete_run
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : check
   // One APB transfer, waits for pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (k == 20) begin
         n_errors++;
         complete_run();
      end
      rd      = prdata;
      er      = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      check(rd, e);
   endtask : rchk
   // Enabled samples for n cycles
   task automatic en(input int n);
      @(posedge clk);
      en_n <= 1'b0;
      repeat (n) @(posedge clk);
      en_n <= 1'b1;
   endtask : en
   // One serial word through a partner, bounded wait
   task automatic sendw(input logic r, input logic [1:0] c, input logic [31:0] w);
      int k;
      @(posedge clk);
      wc    <= c;
      cword <= w;
      rgo   <= r;
      cgo   <= ~r;
      @(posedge clk);
      rgo <= 1'b0;
      cgo <= 1'b0;
      for (k = 0; k < 200; k++) begin
         @(posedge clk);
         if ((r ? rbusy : cbusy) !== 1'b1) break;
      end
      if (k == 200) begin
         n_errors++;
         complete_run();
      end
      repeat (4) @(posedge clk);
   endtask : sendw
   // One enabled sample, product checked next cycle
   task automatic mix1(input logic [31:0] ei);
      @(posedge clk);
      en_n <= 1'b0;
      smp  <= 14'sh1000;
      @(posedge clk);
      en_n <= 1'b1;
      #1;
      check({31'h0, mv}, 32'h0000_0001);
      check({{17{mi[14]}}, mi}, ei);
   endtask : mix1
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      rchk(cnmix_pkg::CNMIX_OFF_ACC, 32'h0000_0000);
      rchk(cnmix_pkg::CNMIX_OFF_ACTFREQ, 32'h0000_0000);
      rchk(cnmix_pkg::CNMIX_OFF_COFHOLD, 32'h0000_0000);
      check(rword, 32'h0000_0000);
   endtask : t_reset
   // Zero phase, then half a cycle of offset
   task automatic t_mixer;
      mix1(32'h0000_2000);
      check({{17{mq[14]}}, mq}, 32'h0000_0000);
      wr(cnmix_pkg::CNMIX_OFF_PHOFF, 32'h0000_0200);
      wr(cnmix_pkg::CNMIX_OFF_XPHS, 32'h0000_0000);
      mix1(32'hFFFF_E000);
   endtask : t_mixer
   task automatic t_hold;
      wr(cnmix_pkg::CNMIX_OFF_CFREQ, 32'h0000_1000);
      rchk(cnmix_pkg::CNMIX_OFF_ACTFREQ, 32'h0000_0000);
      wr(cnmix_pkg::CNMIX_OFF_XFRQ, 32'h0000_0000);
      rchk(cnmix_pkg::CNMIX_OFF_ACTFREQ, 32'h0000_1000);
      en(5);
      rchk(cnmix_pkg::CNMIX_OFF_ACC, 32'h0000_5000);
      rchk(cnmix_pkg::CNMIX_OFF_ACC, 32'h0000_5000);
      apb(1'b0, 8'h7C, 32'h0000_0000);
      check({31'h0, er}, 32'h0000_0001);
   endtask : t_hold
   // Every width code on the carrier port, code 01 on the resampler port
   task automatic t_serial;
      for (int c = 0; c < 4; c++) begin
         wr(cnmix_pkg::CNMIX_OFF_CFG0, 32'(c) << 4);
         sendw(1'b0, 2'(c), 32'hA5C3_5A3C);
         rchk(cnmix_pkg::CNMIX_OFF_COFHOLD, 32'hA5C3_5A3C & ~(32'hFFFF_FFFF >> (8 * (c + 1))));
      end
      wr(cnmix_pkg::CNMIX_OFF_CFG11, 32'h0000_0008);
      sendw(1'b1, 2'b01, 32'h1234_5678);
      check(rword, 32'h1234_0000);
      rchk(cnmix_pkg::CNMIX_OFF_SOFHOLD, 32'h1234_0000);
   endtask : t_serial
   // Offset word held: negative, sum wraps
   task automatic t_sum;
      logic [31:0] x;
      x = 32'h6000_0000 + 32'hA5C3_5A3C;
      wr(cnmix_pkg::CNMIX_OFF_CFG0, 32'h0000_0031);
      wr(cnmix_pkg::CNMIX_OFF_CFREQ, 32'h6000_0000);
      wr(cnmix_pkg::CNMIX_OFF_XFRQ, 32'h0000_0000);
      en(2);
      rchk(cnmix_pkg::CNMIX_OFF_ACC, x + x);
      wr(cnmix_pkg::CNMIX_OFF_CFG0, 32'h0000_0033);
      wr(cnmix_pkg::CNMIX_OFF_XFRQ, 32'h0000_0000);
      en(2);
      rchk(cnmix_pkg::CNMIX_OFF_ACC, 32'hC000_0000);
   endtask : t_sum
   task automatic t_sync;
      wr(cnmix_pkg::CNMIX_OFF_CFG1, 32'h0010_0000);
      wr(cnmix_pkg::CNMIX_OFF_CFREQ, 32'h0123_4567);
      wr(cnmix_pkg::CNMIX_OFF_PHOFF, 32'h0000_0155);
      rchk(cnmix_pkg::CNMIX_OFF_ACTFREQ, 32'h6000_0000);
      @(posedge clk);
      sync <= 1'b1;
      @(posedge clk);
      sync <= 1'b0;
      rchk(cnmix_pkg::CNMIX_OFF_ACTFREQ, 32'h0123_4567);
      rchk(cnmix_pkg::CNMIX_OFF_ACTPHS, 32'h0000_0155);
      rchk(cnmix_pkg::CNMIX_OFF_ACC, 32'h0000_0000);
   endtask : t_sync
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {rst_n, psel, penable, pwrite, paddr, pwdata, sync, pce, cgo, rgo, wc, cword, smp} = '0;
      en_n = 1'b1;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_mixer();
      t_hold();
      t_serial();
      t_sum();
      t_sync();
      complete_run();
   end
endmodule : carrier_nco_mixer_bench
